// ### hdl/core_pkg.sv
/*
 core_pkg: constants, opcodes and carrier types for the
 status / program counter / return stack block.
 assumes one instruction clock and a core that drives
 the execute, flow and event carriers.
*/
package core_pkg;

   // register offsets inside a 128-byte bank
   localparam logic [6:0] OFS_PCL    = 7'h02;
   localparam logic [6:0] OFS_STATUS = 7'h03;
   localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0a;

   // status bit positions
   localparam int BIT_IRP   = 7;
   localparam int BIT_RP_HI = 6;
   localparam int BIT_RP_LO = 5;
   localparam int BIT_TO    = 4;
   localparam int BIT_PD    = 3;
   localparam int BIT_Z     = 2;
   localparam int BIT_DC    = 1;
   localparam int BIT_C     = 0;

   // widths and depths
   localparam int PC_W    = 13;
   localparam int PAGE_W  = 11;
   localparam int LATCH_W = 5;
   localparam int SP_W    = 3;
   localparam int DEPTH   = 8;

   // reset values
   localparam logic [7:0]         STATUS_RST = 8'h18;
   localparam logic [PC_W-1:0]    PC_RST     = 13'h0000;
   localparam logic [LATCH_W-1:0] LATCH_RST  = 5'h00;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD  = 4'h1,
      OP_SUB  = 4'h2,
      OP_AND  = 4'h3,
      OP_IOR  = 4'h4,
      OP_XOR  = 4'h5,
      OP_CLR  = 4'h6,
      OP_INC  = 4'h7,
      OP_DEC  = 4'h8,
      OP_RLF  = 4'h9,
      OP_RRF  = 4'ha
   } alu_op_t;

   typedef struct packed {
      logic       valid;
      alu_op_t    op;
      logic [7:0] a;
      logic [7:0] b;
      logic       dest_status;
   } exec_t;

   typedef struct packed {
      logic              advance;
      logic              call;
      logic              jump;
      logic              ret;
      logic              irq;
      logic [PAGE_W-1:0] target;
   } flow_t;

   typedef struct packed {
      logic timeout;
      logic wdt_clear;
      logic sleep;
   } core_evt_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [8:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

// ### hdl/core_status_pc_stack.sv
/*
 core_status_pc_stack: status register, 13-bit program
 counter with high latch, and 8-deep circular return stack.
 assumes the core presents one carrier per cycle, a bus
 write and an execute never in the same cycle, and the
 register port strobes one cycle long.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module core_status_pc_stack #(
   parameter logic [12:0] IRQ_VECTOR = 13'h0004  // interrupt entry address
) (
   input  wire logic                ref_clk,       // instruction clock
   input  wire logic                arst_n,        // async reset, low
   input  wire core_pkg::reg_req_t  req,           // register port
   output logic [7:0]               rdata,         // read data, cycle after
   input  wire core_pkg::exec_t     exec,          // alu operation
   output logic [7:0]               alu_result,    // result, cycle after
   input  wire core_pkg::flow_t     flow,          // program flow step
   input  wire core_pkg::core_evt_t evt,           // watchdog and sleep events
   output logic [12:0]              fetch_addr,    // program counter
   output logic [7:0]               status,        // status register
   output logic [1:0]               direct_bank,   // direct bank select
   output logic                     indirect_bank  // indirect bank pair
);
   import core_pkg::*;

   typedef struct packed {
      logic [7:0]                 status;
      logic [PC_W-1:0]            pc;
      logic [LATCH_W-1:0]         latch;
      logic [SP_W-1:0]            sp;
      logic [DEPTH-1:0][PC_W-1:0] stack;
      logic [7:0]                 rdata;
      logic [7:0]                 result;
   } st_t;

   st_t cur;
   st_t next_st;

   // alu temporaries
   logic [7:0] opb;
   logic       cin;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] res;
   logic       set_z;
   logic       set_c;
   logic       set_dc;
   logic       new_z;
   logic       new_c;
   logic       new_dc;
   logic       addr_hit_status;
   logic       addr_hit_pcl;
   logic       addr_hit_latch;

   // decode ignores the bank bits so each register shows in every bank
   assign addr_hit_status = (req.addr[6:0] == OFS_STATUS);
   assign addr_hit_pcl    = (req.addr[6:0] == OFS_PCL);
   assign addr_hit_latch  = (req.addr[6:0] == OFS_PC_HIGH_LATCH);

   // adder shared by add and subtract; subtract feeds ~b with carry in
   always_comb begin
      opb = exec.b;
      cin = 1'b0;
      if (exec.op == OP_SUB) begin
         opb = ~exec.b;
         cin = 1'b1;
      end
      sum9 = {1'b0, exec.a} + {1'b0, opb} + {8'h00, cin};
      sum5 = {1'b0, exec.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
   end

   // result and flag selection per operation
   always_comb begin
      res    = 8'h00;
      set_z  = 1'b0;
      set_c  = 1'b0;
      set_dc = 1'b0;
      new_c  = cur.status[BIT_C];
      new_dc = cur.status[BIT_DC];
      unique case (exec.op)
         OP_NONE: begin
            res = exec.a;
         end
         OP_ADD, OP_SUB: begin
            res    = sum9[7:0];
            set_z  = 1'b1;
            set_c  = 1'b1;
            set_dc = 1'b1;
            new_dc = sum5[4];
            new_c  = sum9[8];
         end
         OP_AND: begin
            res   = exec.a & exec.b;
            set_z = 1'b1;
         end
         OP_IOR: begin
            res   = exec.a | exec.b;
            set_z = 1'b1;
         end
         OP_XOR: begin
            res   = exec.a ^ exec.b;
            set_z = 1'b1;
         end
         OP_CLR: begin
            res   = 8'h00;
            set_z = 1'b1;
         end
         OP_INC: begin
            res   = exec.a + 8'h01;
            set_z = 1'b1;
         end
         OP_DEC: begin
            res   = exec.a - 8'h01;
            set_z = 1'b1;
         end
         OP_RLF: begin
            res   = {exec.a[6:0], cur.status[BIT_C]};
            set_c = 1'b1;
            new_c = exec.a[7];
         end
         OP_RRF: begin
            res   = {cur.status[BIT_C], exec.a[7:1]};
            set_c = 1'b1;
            new_c = exec.a[0];
         end
         default: begin
            res = exec.a;
         end
      endcase
      new_z = (res == 8'h00);
   end

   // next state: execute, bus, flow, then watchdog events
   always_comb begin
      next_st       = cur;
      next_st.rdata = 8'h00;

      // execute; flag bits of a status destination come from the alu
      if (exec.valid) begin
         next_st.result = res;
         if (exec.dest_status) begin
            next_st.status[7:5] = res[7:5];
            // a move that leaves every flag alone writes them like data
            if (!set_z && !set_c && !set_dc) begin
               next_st.status[2:0] = res[2:0];
            end
         end
         if (set_z) begin
            next_st.status[BIT_Z] = new_z;
         end
         if (set_c) begin
            next_st.status[BIT_C] = new_c;
         end
         if (set_dc) begin
            next_st.status[BIT_DC] = new_dc;
         end
      end else if (req.wr) begin
         // plain moves into status skip the two event flags
         if (addr_hit_status) begin
            next_st.status[7:5] = req.wdata[7:5];
            next_st.status[2:0] = req.wdata[2:0];
         end
         if (addr_hit_latch) begin
            next_st.latch = req.wdata[LATCH_W-1:0];
         end
      end

      // registered read, data stands one cycle only
      if (req.rd) begin
         if (addr_hit_status) begin
            next_st.rdata = cur.status;
         end else if (addr_hit_pcl) begin
            next_st.rdata = cur.pc[7:0];
         end else if (addr_hit_latch) begin
            next_st.rdata = {3'h0, cur.latch};
         end
      end

      // program flow; latch is never touched here
      if (flow.irq) begin
         next_st.stack[cur.sp] = cur.pc;
         next_st.sp            = cur.sp + 3'h1;
         next_st.pc            = IRQ_VECTOR;
      end else if (flow.call) begin
         next_st.stack[cur.sp] = cur.pc;
         next_st.sp            = cur.sp + 3'h1;
         next_st.pc = {cur.latch[4:3], flow.target};
      end else if (flow.jump) begin
         next_st.pc = {cur.latch[4:3], flow.target};
      end else if (flow.ret) begin
         next_st.sp = cur.sp - 3'h1;
         next_st.pc = cur.stack[cur.sp - 3'h1];
      end else if (req.wr && !exec.valid && addr_hit_pcl) begin
         // a low byte write drags the high bits in from the latch
         next_st.pc = {cur.latch, req.wdata};
      end else if (flow.advance) begin
         next_st.pc = cur.pc + 13'h0001;
      end

      // hardware events override instruction effects on these flags
      if (evt.wdt_clear) begin
         next_st.status[BIT_TO] = 1'b1;
         next_st.status[BIT_PD] = 1'b1;
      end
      if (evt.sleep) begin
         next_st.status[BIT_TO] = 1'b1;
         next_st.status[BIT_PD] = 1'b0;
      end
      // a timeout is never lost against a same-cycle clear
      if (evt.timeout) begin
         next_st.status[BIT_TO] = 1'b0;
      end
   end

   // state register; arithmetic flags come up zero though software may not rely on it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur        <= '0;
         cur.status <= STATUS_RST;
         cur.pc     <= PC_RST;
         cur.latch  <= LATCH_RST;
      end else begin
         cur <= next_st;
      end
   end

   // outputs straight from flops
   assign rdata         = cur.rdata;
   assign alu_result    = cur.result;
   assign fetch_addr    = cur.pc;
   assign status        = cur.status;
   assign direct_bank   = cur.status[BIT_RP_HI:BIT_RP_LO];
   assign indirect_bank = cur.status[BIT_IRP];

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   logic quiet_evt;
   logic only_ret;
   assign quiet_evt = !evt.timeout && !evt.wdt_clear && !evt.sleep;
   assign only_ret  = flow.ret && !flow.irq && !flow.call && !flow.jump;

   property p_flags_computed;
      exec.valid && exec.dest_status && exec.op == OP_ADD
      |=> status[BIT_C] == (({1'b0, $past(exec.a)} + {1'b0, $past(exec.b)}) > 9'h0ff)
          && status[BIT_Z] == (8'($past(exec.a) + $past(exec.b)) == 8'h00);
   endproperty
   a_flags_computed: assert property (p_flags_computed)
      else $error("status flags did not follow add result");

   property p_evt_flags_locked;
      req.wr && !exec.valid && addr_hit_status && quiet_evt
      |=> $stable(status[BIT_TO:BIT_PD]);
   endproperty
   a_evt_flags_locked: assert property (p_evt_flags_locked)
      else $error("write changed timeout or power-down flag");

   property p_clear_status;
      exec.valid && exec.dest_status && exec.op == OP_CLR && quiet_evt
      |=> status[7:5] == 3'h0 && status[BIT_Z] && $stable(status[4:3])
          && $stable(status[1:0]);
   endproperty
   a_clear_status: assert property (p_clear_status)
      else $error("clear of status gave wrong pattern");

   property p_sub_borrow;
      exec.valid && exec.op == OP_SUB
      |=> status[BIT_C] == ($past(exec.a) >= $past(exec.b))
          && status[BIT_DC] == ($past(exec.a[3:0]) >= $past(exec.b[3:0]));
   endproperty
   a_sub_borrow: assert property (p_sub_borrow)
      else $error("subtract carry is not inverted borrow");

   property p_bank_select;
      req.wr && !exec.valid && addr_hit_status
      |=> direct_bank == $past(req.wdata[6:5]) && indirect_bank == $past(req.wdata[7]);
   endproperty
   a_bank_select: assert property (p_bank_select)
      else $error("bank select does not follow status write");

   property p_any_bank_read;
      req.rd && addr_hit_status |=> rdata == $past(status);
   endproperty
   a_any_bank_read: assert property (p_any_bank_read)
      else $error("status not readable at this bank");

   property p_logic_zero;
      exec.valid && exec.op == OP_AND
      |=> status[BIT_Z] == (($past(exec.a) & $past(exec.b)) == 8'h00);
   endproperty
   a_logic_zero: assert property (p_logic_zero)
      else $error("zero flag wrong after logic op");

   property p_rotate_carry;
      exec.valid && exec.op == OP_RLF |=> status[BIT_C] == $past(exec.a[7]);
   endproperty
   a_rotate_carry: assert property (p_rotate_carry)
      else $error("rotate left did not load carry");

   property p_page_call;
      flow.call && !flow.irq |=> fetch_addr == {$past(cur.latch[4:3]), $past(flow.target)};
   endproperty
   a_page_call: assert property (p_page_call)
      else $error("call target not paged by latch");

   property p_call_return;
      flow.call && !flow.irq ##1 only_ret |=> fetch_addr == $past(fetch_addr, 2);
   endproperty
   a_call_return: assert property (p_call_return)
      else $error("return did not restore pushed address");

   property p_latch_kept;
      (flow.call || flow.ret || flow.irq) && !(req.wr && addr_hit_latch)
      |=> $stable(cur.latch);
   endproperty
   a_latch_kept: assert property (p_latch_kept)
      else $error("stack operation changed high latch");

   property p_wrap;
      flow.call && !flow.irq |=> cur.sp == $past(cur.sp) + 3'h1;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("stack pointer did not advance with wrap");

   property p_sleep_flags;
      evt.sleep && !evt.timeout |=> status[BIT_TO] && !status[BIT_PD];
   endproperty
   a_sleep_flags: assert property (p_sleep_flags)
      else $error("sleep flags wrong");

   c_call_ret:   cover property (flow.call ##1 only_ret);
   c_sub_borrow: cover property (exec.valid && exec.op == OP_SUB && exec.a < exec.b);
   c_clr_status: cover property (exec.valid && exec.dest_status && exec.op == OP_CLR);
   c_sp_wrap:    cover property (flow.call && cur.sp == 3'h7);

endmodule // core_status_pc_stack

// ### bench/tb_core_status_pc_stack.sv
/*
 tb_core_status_pc_stack: self-checking bench for the status,
 program counter and return stack block.
 assumes the package core_pkg and a single 200 MHz instruction clock;
 the bench plays both the register master and the core.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module tb_core_status_pc_stack;
   import core_pkg::*;

   localparam logic [4:0] F_ADV = 5'b10000;
   localparam logic [4:0] F_CALL = 5'b01000;
   localparam logic [4:0] F_JMP = 5'b00100;
   localparam logic [4:0] F_RET = 5'b00010;
   localparam logic [4:0] F_IRQ = 5'b00001;

   logic        ref_clk;
   logic        arst_n;
   reg_req_t    req;
   logic [7:0]  rdata;
   exec_t       exec;
   logic [7:0]  alu_result;
   flow_t       flow;
   core_evt_t   evt;
   logic [12:0] fetch_addr;
   logic [7:0]  status;
   logic [1:0]  direct_bank;
   logic        indirect_bank;
   int          err_count;
   int          compares;
   logic [7:0]  rd_val;
   logic [12:0] pc_keep;

   core_status_pc_stack u_core_status_pc_stack (
      .ref_clk       (ref_clk),
      .arst_n        (arst_n),
      .req           (req),
      .rdata         (rdata),
      .exec          (exec),
      .alu_result    (alu_result),
      .flow          (flow),
      .evt           (evt),
      .fetch_addr    (fetch_addr),
      .status        (status),
      .direct_bank   (direct_bank),
      .indirect_bank (indirect_bank)
   );

   // 5 ns instruction clock
   always #2.5 ref_clk = ~ref_clk;

   // one-cycle write strobe; effect is visible after the taking edge
   task automatic reg_wr(input logic [8:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge ref_clk);
      req.wr <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe, so sample there
   task automatic reg_rd(input logic [8:0] addr, output logic [7:0] data);
      @(posedge ref_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      data = rdata;
   endtask

   // one alu step; flags compared as {zero, digit carry, carry}
   task automatic alu(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                      input logic dst, input logic [7:0] exp_res, input logic [2:0] exp_fl);
      @(posedge ref_clk);
      exec <= '{valid: 1'b1, op: op, a: a, b: b, dest_status: dst};
      @(posedge ref_clk);
      exec.valid <= 1'b0;
      #1;
      `CHK(alu_result, exp_res)
      `CHK(status[2:0], exp_fl)
   endtask

   task automatic step(input logic [4:0] kind, input logic [10:0] tgt, input logic [12:0] exp_pc);
      @(posedge ref_clk);
      flow <= {kind, tgt};
      @(posedge ref_clk);
      flow <= '0;
      #1;
      `CHK(fetch_addr, exp_pc)
   endtask

   // event pulse, then look at the timeout and power-down pair
   task automatic event_chk(input logic [2:0] e, input logic [1:0] exp_tp);
      @(posedge ref_clk);
      evt <= e;
      @(posedge ref_clk);
      evt <= '0;
      #1;
      `CHK(status[4:3], exp_tp)
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #(20000 * 5);
      err_count++;
      test_done();
   end

   initial begin
      ref_clk = 1'b0;
      arst_n = 1'b0;
      req = '0;
      exec = '0;
      flow = '0;
      evt = '0;
      err_count = 0;
      compares = 0;
      repeat (16) @(posedge ref_clk);
      #1;
      `CHK(status[7:3], 5'b00011)
      `CHK(fetch_addr, 13'h0000)
      @(posedge ref_clk);
      arst_n <= 1'b1;
      // status reachable at the same offset in all four banks
      reg_wr(9'h003, 8'he7);
      `CHK(status, 8'hff)
      `CHK(direct_bank, 2'b11)
      `CHK(indirect_bank, 1'b1)
      for (int i = 0; i < 4; i++) begin
         reg_rd({i[1:0], 7'h03}, rd_val);
         `CHK(rd_val, 8'hff)
      end
      #5;
      `CHK(rdata, 8'h00)
      reg_rd(9'h07f, rd_val);
      `CHK(rd_val, 8'h00)
      // clear into status keeps carry flags and the reset-status pair
      alu(OP_CLR, 8'h55, 8'h00, 1'b1, 8'h00, 3'b111);
      `CHK(status, 8'h1f)
      alu(OP_ADD, 8'h0f, 8'h01, 1'b1, 8'h10, 3'b010);
      `CHK(status, 8'h1a)
      reg_wr(9'h183, 8'h40);
      `CHK(status, 8'h58)
      `CHK(direct_bank, 2'b10)
      `CHK(indirect_bank, 1'b0)
      // flag table; logic, step and rotate rows build on the carry left by the row before
      alu(OP_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 3'b010);
      alu(OP_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 3'b111);
      alu(OP_SUB, 8'h05, 8'h05, 1'b0, 8'h00, 3'b111);
      alu(OP_SUB, 8'h10, 8'h01, 1'b0, 8'h0f, 3'b001);
      alu(OP_SUB, 8'h00, 8'h01, 1'b0, 8'hff, 3'b000);
      alu(OP_AND, 8'hf0, 8'h0f, 1'b0, 8'h00, 3'b100);
      alu(OP_IOR, 8'hf0, 8'h0f, 1'b0, 8'hff, 3'b000);
      alu(OP_XOR, 8'haa, 8'haa, 1'b0, 8'h00, 3'b100);
      alu(OP_DEC, 8'h02, 8'h00, 1'b0, 8'h01, 3'b000);
      alu(OP_INC, 8'hff, 8'h00, 1'b0, 8'h00, 3'b100);
      alu(OP_RLF, 8'h80, 8'h00, 1'b0, 8'h00, 3'b101);
      alu(OP_RRF, 8'h01, 8'h00, 1'b0, 8'h80, 3'b101);
      alu(OP_RRF, 8'h02, 8'h00, 1'b0, 8'h81, 3'b100);
      // a plain move into status writes every bit except the event pair
      alu(OP_NONE, 8'h27, 8'h00, 1'b1, 8'h27, 3'b111);
      `CHK(status, 8'h3f)
      // internal events own the timeout and power-down pair
      event_chk(3'b001, 2'b10);
      event_chk(3'b100, 2'b00);
      reg_wr(9'h003, 8'h18);
      `CHK(status[4:3], 2'b00)
      event_chk(3'b010, 2'b11);
      // timeout beside a clear: the timeout must not be lost
      event_chk(3'b110, 2'b01);
      // low byte written directly, upper bits only through the latch
      reg_wr(9'h002, 8'h34);
      `CHK(fetch_addr, 13'h0034)
      reg_wr(9'h08a, 8'h1f);
      `CHK(fetch_addr, 13'h0034)
      reg_rd(9'h00a, rd_val);
      `CHK(rd_val, 8'h1f)
      reg_rd(9'h102, rd_val);
      `CHK(rd_val, 8'h34)
      reg_wr(9'h002, 8'h56);
      `CHK(fetch_addr, 13'h1f56)
      step(F_CALL, 11'h123, 13'h1923);
      step(F_RET, 11'h000, 13'h1f56);
      reg_rd(9'h00a, rd_val);
      `CHK(rd_val, 8'h1f)
      step(F_JMP, 11'h011, 13'h1811);
      step(F_IRQ, 11'h000, 13'h0004);
      step(F_ADV, 11'h000, 13'h0005);
      step(F_RET, 11'h000, 13'h1811);
      // nine calls: the ninth overwrites the oldest entry without notice
      reg_wr(9'h00a, 8'h08);
      pc_keep = fetch_addr;
      for (int i = 0; i < 9; i++) begin
         step(F_CALL, 11'h100 + 11'(i), {2'b01, 11'h100 + 11'(i)});
      end
      for (int i = 7; i >= 0; i--) begin
         step(F_RET, 11'h000, {2'b01, 11'h100 + 11'(i)});
      end
      step(F_RET, 11'h000, {2'b01, 11'h107});
      `CHK(fetch_addr !== pc_keep, 1'b1)
      reg_rd(9'h00a, rd_val);
      `CHK(rd_val, 8'h08)
      test_done();
   end
endmodule // tb_core_status_pc_stack
